// ---- dv/positioning_status_flags_properties.sv ----
// assertions on the positioning status flags ports
`timescale 1ns/1ps
module positioning_status_flags_properties (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// inputs
	input wire logic cycleStrobe,
	input wire logic signed [pos_status_pkg::VEL_W-1:0] setpointVelocity,
	input wire logic motionInProgress,
	input wire pos_status_pkg::op_mode_t opMode,
	input wire logic command_active_input,
	input wire logic setpoint_static_input,
	input wire logic activate_task_input,
	input wire logic setpoint_transfer_edge_input,
	input wire logic acceptance_method_input,
	input wire logic referencingDone,
	input wire logic setOutputOne,
	// flags
	input wire logic direct_output_one,
	input wire logic target_reached_flag,
	input wire logic referenced_flag,
	input wire logic task_acknowledge_flag,
	input wire logic setpoint_static_flag,
	input wire logic command_active_flag
);
	import pos_status_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	chk_static_flag: assert property (
		cycleStrobe |=> setpoint_static_flag == ($past(setpointVelocity) == 0)) else $error("static");
	chk_cmd_active: assert property (
		cycleStrobe |=> command_active_flag == $past(motionInProgress)) else $error("cmd active");
	chk_ack_blocks: assert property (
		cycleStrobe && opMode == MODE_BLOCKS |=> task_acknowledge_flag == $past(activate_task_input))
		else $error("ack blocks");
	chk_ack_direct: assert property (
		cycleStrobe && opMode == MODE_DIRECT && !acceptance_method_input
		|=> task_acknowledge_flag == $past(setpoint_transfer_edge_input)) else $error("ack direct");
	chk_hold_idle: assert property (
		!cycleStrobe |=> $stable(target_reached_flag)) else $error("changed without strobe");
	chk_target_blocked: assert property (
		cycleStrobe && !target_reached_flag && (command_active_input || !setpoint_static_input)
		|=> !target_reached_flag) else $error("target set while blocked");
	chk_ref_done: assert property (
		cycleStrobe && referencingDone |=> referenced_flag) else $error("referenced");
	chk_dout_set: assert property (
		cycleStrobe && setOutputOne |=> direct_output_one) else $error("direct out");
endmodule : positioning_status_flags_properties
bind positioning_status_flags positioning_status_flags_properties chk (.*);

// ---- dv/setpoint_gen_model.sv ----
// setpoint generator and controller cycle model in front of the flags block
`timescale 1ns/1ps
module setpoint_gen_model (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// bench control
	input wire logic slow,
	input wire logic signed [pos_status_pkg::VEL_W-1:0] velTarget,
	// generator outputs
	output logic cycleStrobe = 1'b0,
	output logic signed [pos_status_pkg::VEL_W-1:0] setpointVelocity = '0,
	output logic motionAccelerating,
	output logic motionDecelerating,
	output logic motionInProgress
);
	logic [1:0] div = 2'h0;
	// slow mode strobes every third clock, ramp steps 16 a cycle
	always @(posedge sys_clk) begin
		div <= (rst || div == 2'h2) ? 2'h0 : div + 2'h1;
		cycleStrobe <= !rst && (!slow || div == 2'h0);
		if (rst)
			setpointVelocity <= '0;
		else if (cycleStrobe && velTarget != setpointVelocity)
			setpointVelocity <= setpointVelocity + (velTarget > setpointVelocity ? 24'sh10 : -24'sh10);
	end
	assign motionAccelerating = velTarget > setpointVelocity;
	assign motionDecelerating = velTarget < setpointVelocity;
	assign motionInProgress = setpointVelocity != 24'sh0;
endmodule : setpoint_gen_model

// ---- dv/test_positioning_status_flags.sv ----
// self-checking bench for the positioning status flags block
`timescale 1ns/1ps
module test_positioning_status_flags;
	import pos_status_pkg::*;
	logic sys_clk = 1'b0, rst = 1'b1, slow, cycleStrobe;
	logic motionAccelerating, motionDecelerating, motionInProgress;
	logic signed [POS_W-1:0] actualPosition, followingError, cam_switch_position_one;
	logic signed [POS_W-1:0] targetPosition = 32'sh8, stop_cam_minus_position = 32'sh3;
	logic signed [POS_W-1:0] stop_cam_plus_position = 32'shC, cam_switch_position_two = 32'shA;
	logic signed [VEL_W-1:0] actualSpeed, setpointVelocity, limitedVelocity, velTarget;
	logic [VEL_W-1:0] standstill_speed_threshold, maximum_velocity;
	logic [POS_W-1:0] dynamic_following_window, positioning_window = 32'h2;
	logic [GAIN_W-1:0] gainFactor;
	logic [7:0] velocityOverridePct;
	op_mode_t opMode;
	logic taskActive, command_active_input, setpoint_static_input, activate_task_input;
	logic setpoint_transfer_edge_input, acceptance_method_input, referencingDone, referenceLost;
	logic setOutputOne, resetOutputOne, setOutputTwo, resetOutputTwo;
	logic stop_cam_minus_flag, stop_cam_plus_flag, moving_forward_flag, moving_backward_flag;
	logic accelerating_flag, decelerating_flag, standstill_flag, cam_switch_out_one;
	logic cam_switch_out_two, direct_output_one, direct_output_two, following_error_ok_flag;
	logic target_reached_flag, referenced_flag, task_acknowledge_flag, velocity_limiting_flag;
	logic setpoint_static_flag, command_active_flag, mm;
	logic [6:0] eMot;
	logic [1:0] eCam, eDo;
	logic eFe, eTr, eRef, eAck, eLim, eSt, eCmd;
	logic [15:0] seed = 16'h1CCE;
	int eLv, x, d, failures = 0, n_checks = 0, cyc = 0;
	positioning_status_flags dut (.*);
	setpoint_gen_model partner (.*);
	always #25 sys_clk = !sys_clk;
	function automatic int r(int m);
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return int'(seed) % m;
	endfunction : r
	task automatic cmp(string n, logic [31:0] ex, logic [31:0] got);
		n_checks++;
		if (got !== ex) begin
			failures++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, ex, got);
		end
	endtask : cmp
	task automatic drive();
		actualPosition <= r(16);
		actualSpeed <= VEL_W'(r(9) - 4);
		followingError <= r(64) - 32;
		velTarget <= VEL_W'((r(33) - 16) * 16);
		cam_switch_position_one <= r(16);
		standstill_speed_threshold <= VEL_W'(r(5));
		dynamic_following_window <= r(16);
		maximum_velocity <= VEL_W'(r(300));
		gainFactor <= GAIN_W'(r(32));
		velocityOverridePct <= 8'(r(256));
		opMode <= op_mode_t'(r(4));
		{slow, taskActive, command_active_input, setpoint_static_input} <= 4'(r(16));
		{activate_task_input, setpoint_transfer_edge_input, acceptance_method_input} <= 3'(r(8));
		{referencingDone, referenceLost, setOutputOne, resetOutputOne} <= 4'(r(16));
		{setOutputTwo, resetOutputTwo} <= 2'(r(4));
	endtask : drive
	task automatic end_of_test();
		if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : end_of_test
	always @(posedge sys_clk) begin
		if (!rst) begin
			cmp("motion", eMot, {stop_cam_minus_flag, stop_cam_plus_flag,
				moving_forward_flag, moving_backward_flag, accelerating_flag, decelerating_flag,
				standstill_flag});
			cmp("cam", eCam, {cam_switch_out_one, cam_switch_out_two});
			cmp("dout", eDo, {direct_output_one, direct_output_two});
			cmp("ferr", eFe, following_error_ok_flag);
			cmp("target", eTr, target_reached_flag);
			cmp("ref", eRef, referenced_flag);
			cmp("ack", eAck, task_acknowledge_flag);
			cmp("vel", {eLim, eLv[23:0]}, {velocity_limiting_flag, limitedVelocity});
			cmp("static", {eSt, eCmd}, {setpoint_static_flag, command_active_flag});
		end
		drive();
		if (rst) begin
			{eMot, eDo, eFe, eTr, eRef, eAck, eLim, eSt, eCmd} = '0;
			eCam = 2'h3;
			eLv = 0;
		end else if (cycleStrobe) begin
			mm = opMode == MODE_JOG || opMode == MODE_REFAPP || taskActive;
			x = actualSpeed < 0 ? -actualSpeed : actualSpeed;
			eMot = {actualPosition <= stop_cam_minus_position, actualPosition >= stop_cam_plus_position,
				mm && actualSpeed > 0, mm && actualSpeed < 0, mm && motionAccelerating,
				mm && motionDecelerating, x <= int'(standstill_speed_threshold)};
			eCam = {!(actualPosition > cam_switch_position_one),
				!(actualPosition > cam_switch_position_two)};
			eDo[1] = setOutputOne || (eDo[1] && !resetOutputOne);
			eDo[0] = setOutputTwo || (eDo[0] && !resetOutputTwo);
			d = followingError - ((setpointVelocity * int'(gainFactor)) >>> 8);
			eFe = (d < 0 ? -d : d) <= int'(dynamic_following_window);
			d = actualPosition - targetPosition;
			eTr = (d < 0 ? -d : d) <= int'(positioning_window) && setpoint_static_input
				&& (eTr || !command_active_input);
			eRef = referencingDone || (eRef && !referenceLost
				&& !(opMode == MODE_REFAPP && motionInProgress && !eCmd));
			if (opMode == MODE_BLOCKS) eAck = activate_task_input;
			else if (opMode == MODE_DIRECT && !acceptance_method_input) eAck = setpoint_transfer_edge_input;
			x = setpointVelocity * int'(velocityOverridePct) / 100;
			d = int'(maximum_velocity);
			eLim = x > d || x < -d;
			eLv = eLim ? (x > 0 ? d : -d) : x;
			eSt = setpointVelocity == 0;
			eCmd = motionInProgress;
		end
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			failures++;
			end_of_test();
		end
	end
	initial begin
		drive();
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (3000) @(posedge sys_clk);
		end_of_test();
	end
endmodule : test_positioning_status_flags

// ---- hw/pos_status_pkg.sv ----
// constants and types for the positioning status flags block
package pos_status_pkg;
	localparam int POS_W = 32;
	localparam int VEL_W = 24;
	localparam int GAIN_W = 16;
	localparam int GAIN_FRAC = 8;
	localparam logic RST_FLAG = 1'b0;
	localparam logic RST_CAM_OUT = 1'b1;
	typedef enum logic [1:0] {
		MODE_BLOCKS = 2'b00,
		MODE_DIRECT = 2'b01,
		MODE_JOG = 2'b10,
		MODE_REFAPP = 2'b11
	} op_mode_t;
	typedef enum logic [1:0] {
		CAM_OFF = 2'b00,
		CAM_MINUS = 2'b01,
		CAM_PLUS = 2'b10
	} cam_dir_t;
endpackage : pos_status_pkg

// ---- hw/positioning_status_flags.sv ----
// status flags of a basic positioner
// How it works
// - stop cam flag sets on reaching cam, clears leaving opposite to approach
// - standstill flag when absolute speed at or below threshold
// - direction and acceleration flags only while jog, homing or task active
// - cam output one is 0 beyond position one, else 1
// - cam output two is 0 beyond position two, else 1
// - direct outputs set and reset by task commands
// - following error ok when inside window around velocity times gain
// - target reached sets inside positioning window, clears on leaving
// - target reached not set while command active or setpoint moving
// - target reached held while setpoint static input is 1
// - referenced sets on completion, clears on loss or homing start
// - in block mode acknowledge follows activate task input
// - in direct mode with edge acceptance acknowledge follows transfer edge
// - override-scaled velocity clamped to maximum with limiting flag
// - setpoint static flag when setpoint velocity is zero
// - command active flag follows motion in progress input each cycle, so it drops at an intermediate stop
`timescale 1ns/1ps
module positioning_status_flags #(
	parameter int POS_W = pos_status_pkg::POS_W,
	parameter int VEL_W = pos_status_pkg::VEL_W,
	parameter int GAIN_W = pos_status_pkg::GAIN_W
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// controller cycle
	input wire logic cycleStrobe,
	// measured values
	input wire logic signed [POS_W-1:0] actualPosition,
	input wire logic signed [VEL_W-1:0] actualSpeed,
	input wire logic signed [POS_W-1:0] followingError,
	input wire logic signed [POS_W-1:0] targetPosition,
	// setpoint generator
	input wire logic signed [VEL_W-1:0] setpointVelocity,
	input wire logic [7:0] velocityOverridePct,
	input wire logic motionAccelerating,
	input wire logic motionDecelerating,
	input wire logic motionInProgress,
	// configuration
	input wire logic signed [POS_W-1:0] stop_cam_minus_position,
	input wire logic signed [POS_W-1:0] stop_cam_plus_position,
	input wire logic [VEL_W-1:0] standstill_speed_threshold,
	input wire logic signed [POS_W-1:0] cam_switch_position_one,
	input wire logic signed [POS_W-1:0] cam_switch_position_two,
	input wire logic [POS_W-1:0] dynamic_following_window,
	input wire logic [POS_W-1:0] positioning_window,
	input wire logic [VEL_W-1:0] maximum_velocity,
	input wire logic [GAIN_W-1:0] gainFactor,
	// mode and control
	input wire pos_status_pkg::op_mode_t opMode,
	input wire logic taskActive,
	input wire logic command_active_input,
	input wire logic setpoint_static_input,
	input wire logic activate_task_input,
	input wire logic setpoint_transfer_edge_input,
	input wire logic acceptance_method_input,
	input wire logic setOutputOne,
	input wire logic resetOutputOne,
	input wire logic setOutputTwo,
	input wire logic resetOutputTwo,
	input wire logic referencingDone,
	input wire logic referenceLost,
	// flags
	output logic stop_cam_minus_flag,
	output logic stop_cam_plus_flag,
	output logic moving_forward_flag,
	output logic moving_backward_flag,
	output logic accelerating_flag,
	output logic decelerating_flag,
	output logic standstill_flag,
	output logic cam_switch_out_one,
	output logic cam_switch_out_two,
	output logic direct_output_one,
	output logic direct_output_two,
	output logic following_error_ok_flag,
	output logic target_reached_flag,
	output logic referenced_flag,
	output logic task_acknowledge_flag,
	output logic velocity_limiting_flag,
	output logic signed [VEL_W-1:0] limitedVelocity,
	output logic setpoint_static_flag,
	output logic command_active_flag
);
	import pos_status_pkg::*;

	typedef struct packed {
		logic fwd;
		logic bwd;
		logic acc;
		logic dec;
		logic still;
		logic camOne;
		logic camTwo;
		logic outOne;
		logic outTwo;
		logic ferrOk;
		logic target;
		logic refd;
		logic ack;
		logic vlim;
		logic signed [VEL_W-1:0] vel;
		logic spStatic;
		logic cmdActive;
	} flags_t;

	flags_t st_r;
	flags_t st_nxt;

	function automatic logic [POS_W:0] absDiff(input logic signed [POS_W-1:0] a,
			input logic signed [POS_W-1:0] b);
		logic signed [POS_W:0] d;
		d = {a[POS_W-1], a} - {b[POS_W-1], b};
		absDiff = d[POS_W] ? (POS_W+1)'(-d) : (POS_W+1)'(d);
	endfunction : absDiff

	localparam int PROD_W = VEL_W + GAIN_W + 1;
	localparam int SCL_W = VEL_W + 9;
	logic [VEL_W-1:0] absSpeed;
	logic signed [PROD_W-1:0] expectProd;
	logic signed [POS_W-1:0] expectErr;
	logic signed [SCL_W-1:0] scaledVel;
	logic [SCL_W-1:0] scaledMag;
	logic signed [SCL_W-1:0] maxVelS;
	logic inWindow;
	logic motionMode;

	always_comb begin
		st_nxt = st_r;
		absSpeed = actualSpeed[VEL_W-1] ? VEL_W'(-actualSpeed) : VEL_W'(actualSpeed);
		// widen before the product so large speeds times gain do not wrap
		expectProd = PROD_W'(setpointVelocity) * PROD_W'($signed({1'b0, gainFactor}));
		expectErr = POS_W'(expectProd >>> GAIN_FRAC);
		scaledVel = SCL_W'((SCL_W'(setpointVelocity) * $signed({1'b0, velocityOverridePct})) / 100);
		scaledMag = scaledVel[SCL_W-1] ? SCL_W'(-scaledVel) : SCL_W'(scaledVel);
		maxVelS = $signed(SCL_W'(maximum_velocity));
		inWindow = absDiff(actualPosition, targetPosition) <= {1'b0, positioning_window};
		motionMode = (opMode == MODE_JOG) || (opMode == MODE_REFAPP) || taskActive;
		if (cycleStrobe) begin
			st_nxt.still = absSpeed <= standstill_speed_threshold;
			st_nxt.fwd = motionMode && actualSpeed > 0;
			st_nxt.bwd = motionMode && actualSpeed < 0;
			st_nxt.acc = motionMode && motionAccelerating;
			st_nxt.dec = motionMode && motionDecelerating;
			st_nxt.camOne = !(actualPosition > cam_switch_position_one);
			st_nxt.camTwo = !(actualPosition > cam_switch_position_two);
			if (setOutputOne) begin
				st_nxt.outOne = 1'b1;
			end else if (resetOutputOne) begin
				st_nxt.outOne = 1'b0;
			end
			if (setOutputTwo) begin
				st_nxt.outTwo = 1'b1;
			end else if (resetOutputTwo) begin
				st_nxt.outTwo = 1'b0;
			end
			st_nxt.ferrOk = absDiff(followingError, expectErr) <= {1'b0, dynamic_following_window};
			if (!inWindow) begin
				st_nxt.target = 1'b0;
			end else if (st_r.target && setpoint_static_input) begin
				st_nxt.target = 1'b1;
			end else if (!command_active_input && setpoint_static_input) begin
				st_nxt.target = 1'b1;
			end else begin
				st_nxt.target = 1'b0;
			end
			// completion wins over loss in the same cycle
			if (referencingDone) begin
				st_nxt.refd = 1'b1;
			end else if (referenceLost || (opMode == MODE_REFAPP && !st_r.cmdActive
					&& motionInProgress)) begin
				st_nxt.refd = 1'b0;
			end
			if (opMode == MODE_BLOCKS) begin
				st_nxt.ack = activate_task_input;
			end else if (opMode == MODE_DIRECT && !acceptance_method_input) begin
				st_nxt.ack = setpoint_transfer_edge_input;
			end
			if (scaledMag > SCL_W'(maximum_velocity)) begin
				st_nxt.vlim = 1'b1;
				st_nxt.vel = scaledVel[SCL_W-1] ? VEL_W'(-maxVelS) : VEL_W'(maxVelS);
			end else begin
				st_nxt.vlim = 1'b0;
				st_nxt.vel = VEL_W'(scaledVel);
			end
			st_nxt.spStatic = setpointVelocity == 0;
			st_nxt.cmdActive = motionInProgress;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r <= '0;
			st_r.camOne <= RST_CAM_OUT;
			st_r.camTwo <= RST_CAM_OUT;
		end else begin
			st_r <= st_nxt;
		end
	end

	stop_cam_tracker #(
		.POS_W(POS_W)
	) u_cam_minus (
		.sys_clk(sys_clk),
		.rst(rst),
		.cycleStrobe(cycleStrobe),
		.actualPosition(actualPosition),
		.camPosition(stop_cam_minus_position),
		.camIsPlus(1'b0),
		.camFlag(stop_cam_minus_flag)
	);
	stop_cam_tracker #(
		.POS_W(POS_W)
	) u_cam_plus (
		.sys_clk(sys_clk),
		.rst(rst),
		.cycleStrobe(cycleStrobe),
		.actualPosition(actualPosition),
		.camPosition(stop_cam_plus_position),
		.camIsPlus(1'b1),
		.camFlag(stop_cam_plus_flag)
	);

	assign moving_forward_flag = st_r.fwd;
	assign moving_backward_flag = st_r.bwd;
	assign accelerating_flag = st_r.acc;
	assign decelerating_flag = st_r.dec;
	assign standstill_flag = st_r.still;
	assign cam_switch_out_one = st_r.camOne;
	assign cam_switch_out_two = st_r.camTwo;
	assign direct_output_one = st_r.outOne;
	assign direct_output_two = st_r.outTwo;
	assign following_error_ok_flag = st_r.ferrOk;
	assign target_reached_flag = st_r.target;
	assign referenced_flag = st_r.refd;
	assign task_acknowledge_flag = st_r.ack;
	assign velocity_limiting_flag = st_r.vlim;
	assign limitedVelocity = st_r.vel;
	assign setpoint_static_flag = st_r.spStatic;
	assign command_active_flag = st_r.cmdActive;
endmodule : positioning_status_flags

// ---- hw/stop_cam_tracker.sv ----
// one stop cam flag with approach direction memory
`timescale 1ns/1ps
module stop_cam_tracker #(
	parameter int POS_W = 32
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// position and cam
	input wire logic cycleStrobe,
	input wire logic signed [POS_W-1:0] actualPosition,
	input wire logic signed [POS_W-1:0] camPosition,
	input wire logic camIsPlus,
	// flag
	output logic camFlag
);
	import pos_status_pkg::*;
	typedef struct packed {
		logic flag;
		cam_dir_t approach;
	} cam_state_t;
	cam_state_t st_r;
	cam_state_t st_nxt;
	logic beyond;
	logic fromBelow;
	always_comb begin
		st_nxt = st_r;
		beyond = camIsPlus ? (actualPosition >= camPosition) : (actualPosition <= camPosition);
		fromBelow = actualPosition >= camPosition;
		if (cycleStrobe) begin
			if (!st_r.flag && beyond) begin
				st_nxt.flag = 1'b1;
				st_nxt.approach = camIsPlus ? CAM_PLUS : CAM_MINUS;
			end else if (st_r.flag) begin
				// cleared only when backing out opposite to the approach
				if (st_r.approach == CAM_PLUS && actualPosition < camPosition) begin
					st_nxt.flag = 1'b0;
					st_nxt.approach = CAM_OFF;
				end else if (st_r.approach == CAM_MINUS && !fromBelow) begin
					st_nxt.flag = st_r.flag;
				end else if (st_r.approach == CAM_MINUS && actualPosition > camPosition) begin
					st_nxt.flag = 1'b0;
					st_nxt.approach = CAM_OFF;
				end
			end
		end
	end
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r <= '{flag: RST_FLAG, approach: CAM_OFF};
		end else begin
			st_r <= st_nxt;
		end
	end
	assign camFlag = st_r.flag;
endmodule : stop_cam_tracker
